// file: hw/iwf_pkg.sv
package iwf_pkg;

    localparam int           IWF_NUM_SRC    = 8;
    localparam int           IWF_ADDR_W     = 4;
    localparam int           IWF_DATA_W     = 8;

    localparam logic [3:0]   IWF_OFS_ENABLE = 4'h4;
    localparam logic [3:0]   IWF_OFS_FLAGS  = 4'h7;
    localparam logic [3:0]   IWF_OFS_STATUS = 4'hB;
    localparam logic [3:0]   IWF_OFS_RAW    = 4'hC;
    localparam logic [3:0]   IWF_OFS_COUNT  = 4'hD;

    localparam logic [7:0]   IWF_ENABLE_RST = 8'h00;
    localparam logic [7:0]   IWF_COUNT_RST  = 8'h00;
    localparam logic [7:0]   IWF_RDATA_IDLE = 8'h00;
    localparam logic [7:0]   IWF_COUNT_STEP = 8'h01;

    // Status register fields
    localparam int           IWF_STAT_LOW   = 0;
    localparam int           IWF_STAT_DEEP  = 1;
    localparam int           IWF_STAT_LASTD = 2;
    localparam int           IWF_STAT_ANY   = 3;

    typedef enum logic [1:0] {
        IWF_RUN,
        IWF_STOP_LOW,
        IWF_STOP_DEEP
    } iwf_mode_t;

    typedef struct packed {
        logic [IWF_ADDR_W-1:0] addr;
        logic [IWF_DATA_W-1:0] wdata;
        logic                  wr;
        logic                  rd;
    } iwf_reg_req_t;

    typedef struct packed {
        logic cpu_wake;
        logic chip_reset;
    } iwf_exit_t;

endpackage : iwf_pkg

// file: hw/iwf_flag_slice.sv
`timescale 1ns/1ns
module iwf_flag_slice
    import iwf_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic periph_flag,
    input  wire logic enable,
    input  wire logic capture,
    output logic      module_wake_flag
);

    logic cause;
    logic next_cause;

    always_comb begin
        next_cause = cause;
        if (capture && enable && periph_flag) begin
            next_cause = 1'b1;
        end else if (!periph_flag) begin
            // Peripheral cleared its own flag, so the mirror drops too
            next_cause = 1'b0;
        end
    end

    // Only the chip reset reaches this flop, never the wake reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cause <= 1'b0;
        end else begin
            cause <= next_cause;
        end
    end

    assign module_wake_flag = cause & periph_flag;

endmodule : iwf_flag_slice

// file: hw/iwf_top.sv
`timescale 1ns/1ns
module iwf_top
    import iwf_pkg::*;
#(
    parameter int NUM_SRC = IWF_NUM_SRC
)
(
    input  wire logic               CLK,
    input  wire logic               RST_B,
    input  wire logic               WAKE_RST,
    input  wire logic [NUM_SRC-1:0] PERIPH_FLAG,
    input  wire logic               STOP_ENTER,
    input  wire logic               STOP_DEEP,
    input  wire iwf_reg_req_t       REG_REQ,
    output logic [IWF_DATA_W-1:0]   REG_RDATA,
    output iwf_exit_t               EXIT,
    output logic                    LOW_LEAK_ACTIVE
);

    // Reset release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Peripheral flags run on their own low power clocks
    logic [NUM_SRC-1:0] flag_meta;
    logic [NUM_SRC-1:0] flag_sync;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            flag_meta <= '0;
            flag_sync <= '0;
        end else begin
            flag_meta <= PERIPH_FLAG;
            flag_sync <= flag_meta;
        end
    end

    // Wake source enables
    logic [NUM_SRC-1:0] enable;
    logic [NUM_SRC-1:0] next_enable;
    logic               wr_enable;

    assign wr_enable = REG_REQ.wr && (REG_REQ.addr == IWF_OFS_ENABLE);

    always_comb begin
        next_enable = enable;
        if (wr_enable) begin
            next_enable = REG_REQ.wdata[NUM_SRC-1:0];
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            enable <= IWF_ENABLE_RST[NUM_SRC-1:0];
        end else begin
            enable <= next_enable;
        end
    end

    // Power mode tracking
    iwf_mode_t          mode;
    iwf_mode_t          next_mode;
    logic               wake_hit;
    logic               capture;
    logic               last_deep;
    logic               next_last_deep;
    logic               any_exit;
    logic               next_any_exit;
    iwf_exit_t          exit_q;
    iwf_exit_t          next_exit;

    // A flag left set before entry wakes at once, as on silicon
    assign wake_hit = |(enable & flag_sync);
    assign capture  = wake_hit && (mode != IWF_RUN);

    always_comb begin
        next_mode      = mode;
        next_last_deep = last_deep;
        next_any_exit  = any_exit;
        next_exit      = '0;
        unique case (mode)
            IWF_RUN: begin
                if (STOP_ENTER) begin
                    next_mode = STOP_DEEP ? IWF_STOP_DEEP : IWF_STOP_LOW;
                end
            end
            IWF_STOP_LOW: begin
                if (wake_hit) begin
                    next_mode          = IWF_RUN;
                    next_exit.cpu_wake = 1'b1;
                    next_last_deep     = 1'b0;
                    next_any_exit      = 1'b1;
                end
            end
            IWF_STOP_DEEP: begin
                if (wake_hit) begin
                    next_mode            = IWF_RUN;
                    next_exit.chip_reset = 1'b1;
                    next_last_deep       = 1'b1;
                    next_any_exit        = 1'b1;
                end
            end
            default: begin
                next_mode = IWF_RUN;
            end
        endcase
        if (WAKE_RST) begin
            // Wake reset restarts sequencing but spares the flags
            next_mode = IWF_RUN;
            next_exit = '0;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            mode      <= IWF_RUN;
            last_deep <= 1'b0;
            any_exit  <= 1'b0;
            exit_q    <= '0;
        end else begin
            mode      <= next_mode;
            last_deep <= next_last_deep;
            any_exit  <= next_any_exit;
            exit_q    <= next_exit;
        end
    end

    assign EXIT            = exit_q;
    assign LOW_LEAK_ACTIVE = (mode != IWF_RUN);

    // Exit counter survives wake reset for post-mortem reads
    logic [IWF_DATA_W-1:0] exit_count;
    logic [IWF_DATA_W-1:0] next_exit_count;

    always_comb begin
        next_exit_count = exit_count;
        if (capture) begin
            next_exit_count = exit_count + IWF_COUNT_STEP;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            exit_count <= IWF_COUNT_RST;
        end else begin
            exit_count <= next_exit_count;
        end
    end

    // One flag slice per internal source
    logic [NUM_SRC-1:0] module_wake_flag;

    for (genvar i = 0; i < NUM_SRC; i++) begin : g_slice
        iwf_flag_slice u_slice (
            .clk              (CLK),
            .rst_n            (rst_n),
            .periph_flag      (flag_sync[i]),
            .enable           (enable[i]),
            .capture          (capture),
            .module_wake_flag (module_wake_flag[i])
        );
    end

    // Register read
    logic [IWF_DATA_W-1:0] rd_mux;
    logic [IWF_DATA_W-1:0] rdata;
    logic [IWF_DATA_W-1:0] next_rdata;

    always_comb begin
        rd_mux = IWF_RDATA_IDLE;
        unique case (REG_REQ.addr)
            IWF_OFS_ENABLE: begin
                rd_mux[NUM_SRC-1:0] = enable;
            end
            IWF_OFS_FLAGS: begin
                // Live value; a write here has no effect at all
                rd_mux[NUM_SRC-1:0] = module_wake_flag;
            end
            IWF_OFS_STATUS: begin
                rd_mux[IWF_STAT_LOW]   = (mode == IWF_STOP_LOW);
                rd_mux[IWF_STAT_DEEP]  = (mode == IWF_STOP_DEEP);
                rd_mux[IWF_STAT_LASTD] = last_deep;
                rd_mux[IWF_STAT_ANY]   = any_exit;
            end
            IWF_OFS_RAW: begin
                rd_mux[NUM_SRC-1:0] = flag_sync;
            end
            IWF_OFS_COUNT: begin
                rd_mux = exit_count;
            end
            default: begin
                rd_mux = IWF_RDATA_IDLE;
            end
        endcase
    end

    always_comb begin
        next_rdata = IWF_RDATA_IDLE;
        if (REG_REQ.rd) begin
            next_rdata = rd_mux;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= IWF_RDATA_IDLE;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign REG_RDATA = rdata;

endmodule : iwf_top

// file: tb/iwf_top_assertions.sv
`timescale 1ns/1ns
module iwf_top_assertions
    import iwf_pkg::*;
#(
    parameter int NUM_SRC = IWF_NUM_SRC
)
(
    input wire logic                  CLK,
    input wire logic                  RST_B,
    input wire logic                  WAKE_RST,
    input wire logic [NUM_SRC-1:0]    PERIPH_FLAG,
    input wire logic                  STOP_ENTER,
    input wire iwf_reg_req_t          REG_REQ,
    input wire logic [IWF_DATA_W-1:0] REG_RDATA,
    input wire iwf_exit_t             EXIT,
    input wire logic                  LOW_LEAK_ACTIVE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    sequence s_enter;
        STOP_ENTER && !LOW_LEAK_ACTIVE && !WAKE_RST;
    endsequence
    sequence s_left_stop;
        !LOW_LEAK_ACTIVE && $past(LOW_LEAK_ACTIVE);
    endsequence
    AST_STOP_ENTRY: assert property (s_enter |=> LOW_LEAK_ACTIVE)
        else $error("stop not entered");
    AST_LOW_EXIT: assert property (EXIT.cpu_wake |-> s_left_stop ##1 !EXIT.cpu_wake)
        else $error("bad cpu wake pulse");
    AST_DEEP_EXIT: assert property (EXIT.chip_reset |-> s_left_stop ##1 !EXIT.chip_reset)
        else $error("bad chip reset pulse");
    AST_EXIT_EXCL: assert property (!(EXIT.cpu_wake && EXIT.chip_reset))
        else $error("both exit kinds at once");
    AST_EXIT_CAUSE: assert property ((EXIT.cpu_wake || EXIT.chip_reset)
        |-> $past(PERIPH_FLAG, 3) != '0) else $error("exit without source");
    AST_RD_IDLE: assert property (!$past(REG_REQ.rd) |-> REG_RDATA == IWF_RDATA_IDLE)
        else $error("read data outside slot");
    AST_RD_SUBSET: assert property ($past(REG_REQ.rd)
        && $past(REG_REQ.addr) == IWF_OFS_FLAGS |-> (REG_RDATA & ~$past(PERIPH_FLAG, 3)) == '0)
        else $error("flag without live source");
    AST_RST_CLR: assert property (disable iff (1'b0) !RST_B
        |-> REG_RDATA == IWF_RDATA_IDLE && EXIT == '0) else $error("reset not clearing");
endmodule : iwf_top_assertions

// file: tb/iwf_periph_model.sv
`timescale 1ns/1ns
module iwf_periph_model
    import iwf_pkg::*;
(
    input  wire logic              clk,
    output logic [IWF_NUM_SRC-1:0] flag
);
    initial flag = '0;
    // Own status event, level until cleared here
    task automatic raise(input logic [IWF_NUM_SRC-1:0] m);
        @(posedge clk);
        flag <= flag | m;
    endtask : raise
    // Software clears in the peripheral only
    task automatic lower(input logic [IWF_NUM_SRC-1:0] m);
        @(posedge clk);
        flag <= flag & ~m;
    endtask : lower
endmodule : iwf_periph_model

// file: tb/iwf_top_tb.sv
`timescale 1ns/1ns
module iwf_top_tb import iwf_pkg::*;;
    localparam int NUM_SRC = IWF_NUM_SRC;
    logic                  CLK = 1'b0;
    logic                  RST_B = 1'b1;
    logic                  WAKE_RST = 1'b0;
    logic                  STOP_ENTER = 1'b0;
    logic                  STOP_DEEP = 1'b0;
    iwf_reg_req_t          REG_REQ = '0;
    logic [NUM_SRC-1:0]    PERIPH_FLAG;
    logic [IWF_DATA_W-1:0] REG_RDATA;
    iwf_exit_t             EXIT;
    logic                  LOW_LEAK_ACTIVE;
    int                    errors = 0;
    int                    comparisons = 0;
    always #20 CLK = ~CLK;
    iwf_periph_model u_periph (.clk(CLK), .flag(PERIPH_FLAG));
    iwf_top #(.NUM_SRC(NUM_SRC)) DUT (
        .CLK(CLK), .RST_B(RST_B), .WAKE_RST(WAKE_RST), .PERIPH_FLAG(PERIPH_FLAG),
        .STOP_ENTER(STOP_ENTER), .STOP_DEEP(STOP_DEEP), .REG_REQ(REG_REQ),
        .REG_RDATA(REG_RDATA), .EXIT(EXIT), .LOW_LEAK_ACTIVE(LOW_LEAK_ACTIVE));
    task automatic results;
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK);
        REG_REQ <= '{a, d, 1'b1, 1'b0};
        @(posedge CLK);
        REG_REQ <= '0;
    endtask : wr
    // Data stands only in the slot after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge CLK);
        REG_REQ <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge CLK);
        REG_REQ <= '0;
        #1 chk(REG_RDATA, e);
    endtask : rd
    task automatic stop(input logic v);
        @(posedge CLK);
        STOP_ENTER <= 1'b1;
        STOP_DEEP  <= v;
        @(posedge CLK);
        STOP_ENTER <= 1'b0;
    endtask : stop
    task automatic wait_exit(input logic v);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 20 && hit !== 1'b1; i++) begin
            @(posedge CLK);
            #1 hit = v ? EXIT.chip_reset : EXIT.cpu_wake;
        end
        chk({7'h00, hit}, 8'h01);
        // Nothing after a lost wake means much, so stop here
        if (hit !== 1'b1) begin
            results();
        end
    endtask : wait_exit
    task automatic t_reset;
        rd(IWF_OFS_FLAGS, 8'h00);
        rd(IWF_OFS_STATUS, 8'h00);
        rd(IWF_OFS_COUNT, IWF_COUNT_RST);
    endtask : t_reset
    task automatic t_shallow;
        wr(IWF_OFS_ENABLE, 8'h09);
        rd(IWF_OFS_ENABLE, 8'h09);
        stop(1'b0);
        rd(IWF_OFS_STATUS, 8'h01);
        // Disabled source first: must not end the stop
        u_periph.raise(8'h20);
        repeat (6) @(posedge CLK);
        #1 chk({7'h00, LOW_LEAK_ACTIVE}, 8'h01);
        rd(IWF_OFS_RAW, 8'h20);
        u_periph.raise(8'h08);
        wait_exit(1'b0);
        rd(IWF_OFS_FLAGS, 8'h08);
        rd(IWF_OFS_STATUS, 8'h08);
        rd(IWF_OFS_COUNT, 8'h01);
        wr(IWF_OFS_FLAGS, 8'hFF);
        rd(IWF_OFS_FLAGS, 8'h08);
        u_periph.lower(8'h28);
        repeat (5) @(posedge CLK);
        rd(IWF_OFS_FLAGS, 8'h00);
    endtask : t_shallow
    task automatic t_deep;
        stop(1'b1);
        u_periph.raise(8'h01);
        wait_exit(1'b1);
        rd(IWF_OFS_STATUS, 8'h0C);
        @(posedge CLK);
        WAKE_RST <= 1'b1;
        @(posedge CLK);
        WAKE_RST <= 1'b0;
        rd(IWF_OFS_FLAGS, 8'h01);
        rd(IWF_OFS_STATUS, 8'h0C);
        rd(IWF_OFS_COUNT, 8'h02);
        @(posedge CLK);
        RST_B <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_B <= 1'b1;
        repeat (4) @(posedge CLK);
        // Source still high, yet chip reset drops the cause
        rd(IWF_OFS_FLAGS, 8'h00);
        rd(IWF_OFS_RAW, 8'h01);
        rd(IWF_OFS_ENABLE, IWF_ENABLE_RST);
        rd(IWF_OFS_COUNT, IWF_COUNT_RST);
        rd(IWF_OFS_STATUS, 8'h00);
        u_periph.lower(8'h01);
    endtask : t_deep
    initial begin
        // A real falling edge, so the async reset acts before the first clock
        RST_B <= 1'b0;
        repeat (5) @(posedge CLK);
        RST_B <= 1'b1;
        repeat (4) @(posedge CLK);
        t_reset();
        t_shallow();
        t_deep();
        results();
    end
endmodule : iwf_top_tb
bind iwf_top iwf_top_assertions #(.NUM_SRC(NUM_SRC)) u_chk (
    .CLK(CLK), .RST_B(RST_B), .WAKE_RST(WAKE_RST), .PERIPH_FLAG(PERIPH_FLAG),
    .STOP_ENTER(STOP_ENTER), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
    .EXIT(EXIT), .LOW_LEAK_ACTIVE(LOW_LEAK_ACTIVE));
